// ### rtl/flyback_defs.vh
// Constants shared by the flyback peak current protection core
`ifndef FLYBACK_DEFS_VH
`define FLYBACK_DEFS_VH
// Clock period in picoseconds (200 MHz)
`define CLK_PS            32'd5000
// Times in their own units, then counts derived from them
`define LEB_NORMAL_NS     32'd275
`define LEB_ABNORMAL_NS   32'd125
`define MAX_ON_US         32'd32
`define VALLEY_SHORT_US   32'd6
`define VALLEY_LONG_US    32'd100
`define SOFTSTART_MS      32'd4
`define OVERLOAD_STEP_MS  32'd10
`define OVERLOAD_FULL_MS  32'd160
`define RECOVERY_DELAY_MS 32'd2000
`define DITHER_HZ         32'd1300
// Least times round up, longest times round down
`define LEB_NORMAL_CYC   ((`LEB_NORMAL_NS*32'd1000+`CLK_PS-32'd1)/`CLK_PS)
`define LEB_ABNORMAL_CYC ((`LEB_ABNORMAL_NS*32'd1000+`CLK_PS-32'd1)/`CLK_PS)
`define MAX_ON_CYC       ((`MAX_ON_US*32'd1000000)/`CLK_PS)
`define VALLEY_SHORT_CYC ((`VALLEY_SHORT_US*32'd1000000)/`CLK_PS)
`define VALLEY_LONG_CYC  ((`VALLEY_LONG_US*32'd1000000)/`CLK_PS)
// Setpoint scale: 10 bit code, 1 lsb = 1 mV
`define SET_W             10
`define PEAK_LIMIT_MV     10'h320
`define FREEZE_MV         10'h0c8
`define FB_SHIFT          2
// Overload steps needed to reach the full duration
`define OVERLOAD_STEPS    5'h10
// Abnormal overcurrent detections before fault
`define ABNORMAL_COUNT    3'h4
// Dither ramp full scale in steps
`define DITHER_FULL       7'h64
// Run states
`define ST_CHARGE 3'h0
`define ST_RUN    3'h1
`define ST_LATCH  3'h2
`define ST_WAIT   3'h3
`define ST_HOLD   3'h4
`endif

// ### rtl/flyback_peak_current_protection.v
// Peak current control and protection sequencing of the flyback controller core
// Operation
// - Nominal setpoint equals feedback divided by four
// - Soft-start ramps clamp from zero to limit
// - On-time maximum is limit minus power input
// - Setpoint never below frozen minimum level
// - Second clamp caps setpoint at peak limit
// - Ignore current sense during normal blanking
// - End pulse when sense exceeds setpoint
// - Maximum peak trip enables overload timer
// - Overload timer steps up and down
// - Normal trip wins, timer counts down
// - Latch: stop, hold bias until clear
// - Auto-recovery: stop, wait, delay, recharge
// - Abnormal check uses short blanking interval
// - Four consecutive abnormal trips cause fault
// - Clean pulse clears abnormal counter
// - Force pulse end at maximum on-time
// - Long valley timeout during soft-start
// - Ignore fault input during soft-start
// - Triangular dither current at low frequency
// - Dither only high line, not foldback
// - Thermal trip stops, restarts after clear
// - Thermal cleared by reset, brown-out, savings; the code also clears it once the temperature drops while charging
// - Foldback entered at sixth valley low feedback
`include "flyback_defs.vh"
module flyback_peak_current_protection #(
    parameter [31:0] SOFTSTART_CYC     = (`SOFTSTART_MS*32'd1000000000)/`CLK_PS,
    parameter [31:0] OVERLOAD_STEP_CYC = (`OVERLOAD_STEP_MS*32'd1000000000)/`CLK_PS,
    parameter [31:0] RECOVERY_CYC      = (`RECOVERY_DELAY_MS*32'd1000000000)/`CLK_PS,
    parameter [31:0] DITHER_STEP_CYC   = 32'd1000000000/(`CLK_PS*`DITHER_HZ*32'd2/32'd1000)
                                         /{25'h0, `DITHER_FULL}
) (
    input  wire                clk,
    input  wire                reset_n,
    input  wire [`SET_W-1:0]   feedback_voltage,
    input  wire [`SET_W-1:0]   overpower_limit_input,
    input  wire                overpower_positive,
    input  wire                sense_above_setpoint,
    input  wire                sense_above_peak_limit,
    input  wire                sense_above_overpower_limit,
    input  wire                sense_above_abnormal_limit,
    input  wire                valley_detect_input,
    input  wire                fault_input_trip,
    input  wire                thermal_trip_level,
    input  wire                supply_start_level,
    input  wire                supply_stop_level,
    input  wire                supply_clear_level,
    input  wire                brownout_fault,
    input  wire                power_savings,
    input  wire                high_line,
    input  wire                sixth_valley,
    input  wire                feedback_below_foldback,
    input  wire                feedback_above_foldback_exit,
    input  wire                latch_option,
    input  wire                dither_fitted,
    output reg                 gate_drive_out,
    output reg  [`SET_W-1:0]   current_setpoint,
    output reg  [6:0]          dither_current,
    output reg                 supply_hold_level,
    output reg                 overload_fault,
    output reg                 foldback_mode,
    output reg                 softstart_active,
    output reg                 fault_active
);

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for every asynchronous comparator input
    localparam NSYNC = 17;
    wire [NSYNC-1:0] raw_in = {sense_above_setpoint, sense_above_peak_limit,
                               sense_above_overpower_limit, sense_above_abnormal_limit,
                               valley_detect_input, fault_input_trip, thermal_trip_level,
                               supply_start_level, supply_stop_level, supply_clear_level,
                               brownout_fault, power_savings, high_line, sixth_valley,
                               feedback_below_foldback, feedback_above_foldback_exit,
                               overpower_positive};
    reg  [NSYNC-1:0] sync_a;
    reg  [NSYNC-1:0] sync_b;
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            // Stage one feeds stage two only
            always @(posedge clk) begin
                if (!reset_n) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate
    wire s_pwm   = sync_b[16];
    wire s_peak  = sync_b[15];
    wire s_opp   = sync_b[14];
    wire s_abn   = sync_b[13];
    wire s_zcd   = sync_b[12];
    wire s_fault = sync_b[11];
    wire s_therm = sync_b[10];
    wire s_von   = sync_b[9];
    wire s_voff  = sync_b[8];
    wire s_vrst  = sync_b[7];
    wire s_bo    = sync_b[6];
    wire s_psm   = sync_b[5];
    wire s_hl    = sync_b[4];
    wire s_v6    = sync_b[3];
    wire s_fblo  = sync_b[2];
    wire s_fbhi  = sync_b[1];
    wire s_opos  = sync_b[0];

    ////////////////////////////////////////////////////////////////////////////
    // Static options caught on the first clock after reset release
    reg opt_latch;
    reg opt_dither;
    reg opt_taken;
    always @(posedge clk) begin
        if (!reset_n) begin
            opt_latch  <= 1'b0;
            opt_dither <= 1'b0;
            opt_taken  <= 1'b0;
        end else if (!opt_taken) begin
            opt_latch  <= latch_option;
            opt_dither <= dither_fitted;
            opt_taken  <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Run state machine: charge, run, latched, wait for stop level, bias hold
    reg  [2:0]  state;
    reg  [31:0] hold_cnt;
    reg  [31:0] ss_cnt;
    reg         thermal_latched;
    reg  [2:0]  abn_cnt;
    reg  [4:0]  ovl_level;
    wire running      = (state == `ST_RUN);
    wire abn_fault    = (abn_cnt == `ABNORMAL_COUNT);
    wire ovl_fault    = (ovl_level == `OVERLOAD_STEPS);
    wire ext_fault    = s_fault && !softstart_active;
    wire trip         = ovl_fault || abn_fault;
    wire faults_gone  = !s_therm && !s_bo && !s_psm && !thermal_latched;
    always @(posedge clk) begin
        if (!reset_n) begin
            state    <= `ST_CHARGE;
            hold_cnt <= 32'h0;
        end else begin
            case (state)
                `ST_CHARGE: begin
                    if (s_von && faults_gone && opt_taken) begin
                        state <= `ST_RUN;
                    end
                end
                `ST_RUN: begin
                    if (trip && opt_latch) begin
                        state <= `ST_LATCH;
                    end else if (trip || ext_fault) begin
                        state <= `ST_WAIT;
                    end else if (thermal_latched || s_bo || s_psm) begin
                        state <= `ST_CHARGE;
                    end
                end
                `ST_LATCH: begin
                    if (s_vrst) begin
                        state <= `ST_CHARGE;
                    end
                end
                `ST_WAIT: begin
                    hold_cnt <= 32'h0;
                    if (s_voff) begin
                        state <= `ST_HOLD;
                    end
                end
                `ST_HOLD: begin
                    hold_cnt <= hold_cnt + 32'h1;
                    if (hold_cnt >= RECOVERY_CYC - 32'h1) begin
                        state <= `ST_CHARGE;
                    end
                end
                default: state <= `ST_CHARGE;
            endcase
        end
    end

    // Thermal flag clears on supply clear, brown-out or power savings, or once the temperature drops while charging
    always @(posedge clk) begin
        if (!reset_n) begin
            thermal_latched <= 1'b0;
        end else if (s_vrst || s_bo || s_psm) begin
            thermal_latched <= 1'b0;
        end else if (s_therm) begin
            thermal_latched <= 1'b1;
        end else if (state == `ST_CHARGE) begin
            thermal_latched <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Soft-start timer restarts at each power-up
    always @(posedge clk) begin
        if (!reset_n || !running) begin
            ss_cnt <= 32'h0;
        end else if (ss_cnt < SOFTSTART_CYC) begin
            ss_cnt <= ss_cnt + 32'h1;
        end
    end
    wire ss_on = running && (ss_cnt < SOFTSTART_CYC);
    // Ramp clamp in mV; 64-bit product avoids overflow
    wire [63:0] ramp_prod = {32'h0, ss_cnt} * {54'h0, `PEAK_LIMIT_MV};
    wire [`SET_W-1:0] ramp_mv = ss_on ? ramp_prod[`SET_W-1:0] : `PEAK_LIMIT_MV;
    wire [63:0] ramp_div = ramp_prod / {32'h0, SOFTSTART_CYC};
    wire [`SET_W-1:0] ss_clamp = ss_on ? ramp_div[`SET_W-1:0] : ramp_mv;

    ////////////////////////////////////////////////////////////////////////////
    // Setpoint chain: FB/4, soft-start, OVERPOWER_LIMIT_INPUT, second clamp, frozen floor
    reg [`SET_W-1:0] next_setpoint;
    reg [`SET_W-1:0] opp_max;
    always @* begin
        next_setpoint = feedback_voltage >> `FB_SHIFT;
        opp_max = (overpower_limit_input > `PEAK_LIMIT_MV) ? `SET_W'h0
                  : (`PEAK_LIMIT_MV - overpower_limit_input);
        if (s_opos) begin
            opp_max = `PEAK_LIMIT_MV;
        end
        if (next_setpoint > ss_clamp) begin
            next_setpoint = ss_clamp;
        end
        if (gate_drive_out && next_setpoint > opp_max) begin
            next_setpoint = opp_max;
        end
        if (next_setpoint > `PEAK_LIMIT_MV) begin
            next_setpoint = `PEAK_LIMIT_MV;
        end
        if (next_setpoint < `FREEZE_MV) begin
            next_setpoint = `FREEZE_MV;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gate drive: on-time counter, blanking, termination, valley restart
    reg  [31:0] on_cnt;
    reg  [31:0] off_cnt;
    reg         abn_seen;
    wire [31:0] valley_to = ss_on ? `VALLEY_LONG_CYC : `VALLEY_SHORT_CYC;
    wire blank_ok   = on_cnt >= `LEB_NORMAL_CYC;
    wire blank2_ok  = on_cnt >= `LEB_ABNORMAL_CYC;
    wire pwm_end    = blank_ok && s_pwm;
    wire peak_trip  = blank_ok && (s_peak || s_opp);
    wire abn_trip   = blank2_ok && s_abn;
    wire max_on     = on_cnt >= `MAX_ON_CYC - 32'h1;
    wire pulse_end  = gate_drive_out && (pwm_end || peak_trip || abn_trip || max_on);
    always @(posedge clk) begin
        if (!reset_n || !running || trip) begin
            gate_drive_out <= 1'b0;
            on_cnt         <= 32'h0;
            off_cnt        <= 32'h0;
            abn_seen       <= 1'b0;
        end else if (gate_drive_out) begin
            on_cnt <= on_cnt + 32'h1;
            if (abn_trip) begin
                abn_seen <= 1'b1;
            end
            if (pulse_end) begin
                gate_drive_out <= 1'b0;
                off_cnt        <= 32'h0;
            end
        end else begin
            on_cnt <= 32'h0;
            off_cnt <= off_cnt + 32'h1;
            // Restart on valley or on off-time timeout
            if (s_zcd || off_cnt >= valley_to - 32'h1) begin
                gate_drive_out <= 1'b1;
                abn_seen       <= 1'b0;
            end
        end
    end

    // Abnormal counter: consecutive trips counted, clean pulse clears
    always @(posedge clk) begin
        if (!reset_n || !running) begin
            abn_cnt <= 3'h0;
        end else if (pulse_end && (abn_trip || abn_seen)) begin
            if (!abn_fault) begin
                abn_cnt <= abn_cnt + 3'h1;
            end
        end else if (pulse_end) begin
            abn_cnt <= 3'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overload up/down timer in fixed steps; PWM trip takes precedence
    reg [31:0] step_cnt;
    reg        ovl_cycle;
    always @(posedge clk) begin
        if (!reset_n || !running) begin
            ovl_cycle <= 1'b0;
        end else if (pulse_end) begin
            ovl_cycle <= peak_trip && !pwm_end;
        end
    end
    always @(posedge clk) begin
        if (!reset_n || state == `ST_CHARGE) begin
            step_cnt  <= 32'h0;
            ovl_level <= 5'h0;
        end else if (running) begin
            step_cnt <= (step_cnt >= OVERLOAD_STEP_CYC - 32'h1) ? 32'h0 : step_cnt + 32'h1;
            if (step_cnt >= OVERLOAD_STEP_CYC - 32'h1) begin
                if (ovl_cycle && !ovl_fault) begin
                    ovl_level <= ovl_level + 5'h1;
                end else if (!ovl_cycle && ovl_level != 5'h0) begin
                    ovl_level <= ovl_level - 5'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Foldback mode with hysteresis, and triangular dither
    reg [31:0] dith_cnt;
    reg        dith_up;
    wire dith_en = opt_dither && s_hl && !foldback_mode && running;
    always @(posedge clk) begin
        if (!reset_n || !running) begin
            foldback_mode <= 1'b0;
        end else if (s_v6 && s_fblo) begin
            foldback_mode <= 1'b1;
        end else if (s_fbhi) begin
            foldback_mode <= 1'b0;
        end
    end
    always @(posedge clk) begin
        if (!reset_n || !dith_en) begin
            dith_cnt       <= 32'h0;
            dith_up        <= 1'b1;
            dither_current <= 7'h0;
        end else if (dith_cnt >= DITHER_STEP_CYC - 32'h1) begin
            dith_cnt <= 32'h0;
            if (dith_up) begin
                dither_current <= dither_current + 7'h1;
                dith_up <= (dither_current != `DITHER_FULL - 7'h1);
            end else begin
                dither_current <= dither_current - 7'h1;
                dith_up <= (dither_current == 7'h1);
            end
        end else begin
            dith_cnt <= dith_cnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered status outputs
    always @(posedge clk) begin
        if (!reset_n) begin
            current_setpoint  <= `FREEZE_MV;
            supply_hold_level <= 1'b0;
            overload_fault    <= 1'b0;
            softstart_active  <= 1'b0;
            fault_active      <= 1'b0;
        end else begin
            current_setpoint  <= next_setpoint;
            supply_hold_level <= (state == `ST_LATCH) || (state == `ST_HOLD);
            overload_fault    <= ovl_fault;
            softstart_active  <= ss_on;
            fault_active      <= (state != `ST_RUN) && (state != `ST_CHARGE);
        end
    end

endmodule // flyback_peak_current_protection

// ### verification/flyback_peak_current_protection_assertions.sv
// Concurrent checks on the ports of the flyback peak current protection core
`include "flyback_defs.vh"
module flyback_protection_checker (
    input wire              clk,
    input wire              reset_n,
    input wire              dither_fitted,
    input wire              gate_drive_out,
    input wire [`SET_W-1:0] current_setpoint,
    input wire [6:0]        dither_current,
    input wire              supply_hold_level,
    input wire              fault_active
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [15:0] on_len;
    ////////////////////////////////////////////////////////////////////////////////
    // Gate high cycles; a counter keeps long limits cheap
    always @(posedge clk) begin
        if (!reset_n || !gate_drive_out) on_len <= 16'h0;
        else on_len <= on_len + 16'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Pulse end; a fault may cut it short
    sequence pulse_end_s;
        gate_drive_out ##1 !gate_drive_out;
    endsequence
    sequence fault_soon_s;
        ##[0:3] fault_active;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    setpoint_bounds_a: assert property (
        current_setpoint >= `FREEZE_MV && current_setpoint <= `PEAK_LIMIT_MV)
        else $error("setpoint left its band");
    on_time_limit_a: assert property (on_len <= `MAX_ON_CYC)
        else $error("pulse too long");
    min_pulse_a: assert property (
        pulse_end_s |-> (on_len >= `LEB_ABNORMAL_CYC) or fault_soon_s)
        else $error("pulse ended inside blanking");
    fault_quiet_a: assert property (fault_active ##1 fault_active |-> !gate_drive_out)
        else $error("gate driven during fault");
    hold_quiet_a: assert property (supply_hold_level |-> !gate_drive_out)
        else $error("gate on at bias");
    start_clean_a: assert property (
        $rose(gate_drive_out) |-> !fault_active && !supply_hold_level)
        else $error("pulse from fault");
    dither_bound_a: assert property (dither_current <= `DITHER_FULL)
        else $error("dither over scale");
    dither_strap_a: assert property (!dither_fitted |-> dither_current == 7'h0)
        else $error("dither unfitted");
endmodule // flyback_protection_checker

bind flyback_peak_current_protection flyback_protection_checker checker_u (.*);

// ### verification/power_stage_model.sv
// Behavioural power switch and flyback stage seen from the gate drive
module power_stage_model (
    input  wire        clk,
    input  wire        gate_drive_out,
    input  wire [1:0]  mode,
    input  wire [15:0] trip_cyc,
    input  wire [15:0] valley_cyc,
    output wire        sense_above_setpoint,
    output wire        sense_above_peak_limit,
    output wire        sense_above_overpower_limit,
    output wire        sense_above_abnormal_limit,
    output wire        valley_detect_input
);
    timeunit 1ns;
    timeprecision 100ps;
    reg  [15:0] on_cnt  = 16'h0;
    reg  [15:0] off_cnt = 16'h0;
    wire        hit;
    ////////////////////////////////////////////////////////////////////////////////
    // Off time saturates so a missing valley stays missing
    always @(posedge clk) begin
        on_cnt  <= gate_drive_out ? on_cnt + 16'h1 : 16'h0;
        off_cnt <= gate_drive_out ? 16'h0 : off_cnt + {15'h0, off_cnt != 16'hffff};
    end
    // Modes: 0 normal, 1 overload, 2 normal and peak together, 3 winding short
    assign hit = gate_drive_out && on_cnt >= trip_cyc;
    assign sense_above_setpoint        = hit && mode != 2'h1;
    assign sense_above_peak_limit      = hit && mode != 2'h0;
    assign sense_above_overpower_limit = hit && mode == 2'h1;
    assign sense_above_abnormal_limit  = hit && mode == 2'h3;
    // Valley lasts four cycles so the synchroniser cannot miss it
    assign valley_detect_input = !gate_drive_out && off_cnt >= valley_cyc
                                 && off_cnt < valley_cyc + 16'h4;
endmodule // power_stage_model

// ### verification/tb_flyback_peak_current_protection.sv
// Self-checking bench of the flyback peak current protection core
module tb_flyback_peak_current_protection;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'h0, reset_n = 1'h0, q;
    logic [9:0]  feedback_voltage = 10'h190, overpower_limit_input = 10'h0;
    logic        overpower_positive = 1'h0, fault_input_trip = 1'h0, thermal_trip_level = 1'h0;
    logic        supply_start_level = 1'h0, supply_stop_level = 1'h0, supply_clear_level = 1'h0;
    logic        brownout_fault = 1'h0, power_savings = 1'h0, high_line = 1'h1;
    logic        sixth_valley = 1'h0, feedback_below_foldback = 1'h0;
    logic        feedback_above_foldback_exit = 1'h0, latch_option = 1'h0, dither_fitted = 1'h1;
    logic [1:0]  mode = 2'h0;
    logic [15:0] trip_cyc = 16'h64, valley_cyc = 16'hffff;
    wire         sense_above_setpoint, sense_above_peak_limit, sense_above_overpower_limit;
    wire         sense_above_abnormal_limit, valley_detect_input, gate_drive_out;
    wire         supply_hold_level, overload_fault, foldback_mode, softstart_active, fault_active;
    wire [9:0]   current_setpoint;
    wire [6:0]   dither_current, obs;
    int          fails = 0, total_checks = 0, seed = 32'hacc2, n, len, i;
    logic [9:0]  corner [4] = '{10'h000, 10'h3ff, 10'h31f, 10'h324};
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watched flags
    always #2.5 clk = ~clk;
    assign obs = {dither_current == 7'h64, foldback_mode, supply_hold_level, fault_active,
                  overload_fault, softstart_active, gate_drive_out};
    // Short timers keep the run brief
    flyback_peak_current_protection #(.SOFTSTART_CYC(32'hfa0), .OVERLOAD_STEP_CYC(32'h64),
        .RECOVERY_CYC(32'hc8), .DITHER_STEP_CYC(32'h4)) dut_u (.*);
    power_stage_model stage_u (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        if (fails == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask
    task chk_val(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: value got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Bounded wait; running out is a mismatch
    task wait_obs(input logic [2:0] idx, input logic val, input int bound, output int cnt);
        cnt = 0;
        while (obs[idx] !== val) begin
            @(negedge clk);
            cnt++;
            if (cnt > bound) begin
                fails++;
                $display("Error at %0t: wait on flag %0d timed out", $time, idx);
                end_of_test;
            end
        end
    endtask
    // Gap before a pulse and its width
    task pulse(output int gap, output int width);
        wait_obs(3'h0, 1'h1, 32'h7530, gap);
        wait_obs(3'h0, 1'h0, 32'h1b58, width);
    endtask
    task pulses(input logic [1:0] m, input int k);
        mode = m;
        repeat (k) pulse(n, len);
    endtask
    // Did the gate rise over a stretch
    task quiet(input int cyc, output logic seen);
        seen = 1'h0;
        repeat (cyc) begin
            @(negedge clk);
            seen = seen | gate_drive_out;
        end
    endtask
    task do_reset(input logic lat);
        @(negedge clk);
        reset_n = 1'h0;
        latch_option = lat;
        supply_start_level = 1'h0;
        repeat (16) @(negedge clk);
        reset_n = 1'h1;
    endtask
    // Feedback/4, capped, floored
    function logic [9:0] exp_set();
        logic [9:0] lim;
        exp_set = feedback_voltage >> 2;
        lim = overpower_positive ? 10'h320 : 10'h320 - overpower_limit_input;
        if (exp_set > lim) exp_set = lim;
        if (exp_set < 10'h0c8) exp_set = 10'h0c8;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'h0);
        supply_start_level = 1'h1;
        wait_obs(3'h1, 1'h1, 32'h32, n);
        fault_input_trip = 1'h1;
        repeat (32'hc8) @(negedge clk);
        chk_bit(fault_active, 1'h0);
        fault_input_trip = 1'h0;
        trip_cyc = 16'ha;
        pulse(n, len);
        chk_bit(n > 32'h514, 1'h1);
        chk_bit(len >= 32'h37 && len <= 32'h3e, 1'h1);
        valley_cyc = 16'h32;
        wait_obs(3'h1, 1'h0, 32'h1770, n);
        wait_obs(3'h6, 1'h1, 32'h7d0, n);
        sixth_valley = 1'h1;
        feedback_below_foldback = 1'h1;
        wait_obs(3'h5, 1'h1, 32'h32, n);
        repeat (32'h14) @(negedge clk);
        chk_val({3'h0, dither_current}, 10'h0);
        sixth_valley = 1'h0;
        feedback_below_foldback = 1'h0;
        feedback_above_foldback_exit = 1'h1;
        wait_obs(3'h5, 1'h0, 32'h32, n);
        feedback_above_foldback_exit = 1'h0;
        high_line = 1'h0;
        repeat (32'h14) @(negedge clk);
        chk_val({3'h0, dither_current}, 10'h0);
        high_line = 1'h1;
        for (i = 0; i < 32'h10; i++) begin
            feedback_voltage = (i < 32'h4) ? corner[i] : 10'($random(seed));
            overpower_limit_input = 10'({$random(seed)} % 32'hfb);
            overpower_positive = 1'($random(seed));
            trip_cyc = 16'(32'h3c + {$random(seed)} % 32'hf1);
            pulse(n, len);
            wait_obs(3'h0, 1'h1, 32'h7530, n);
            repeat (32'ha) @(negedge clk);
            chk_val(current_setpoint, exp_set());
            wait_obs(3'h0, 1'h0, 32'h1b58, len);
            chk_bit(len + 32'ha >= trip_cyc && len <= trip_cyc, 1'h1);
        end
        trip_cyc = 16'hffff;
        pulse(n, len);
        chk_bit(len >= 32'h18fe && len <= 32'h1902, 1'h1);
        trip_cyc = 16'h64;
        valley_cyc = 16'hffff;
        pulses(2'h0, 2);
        chk_bit(n >= 32'h4a6 && n <= 32'h4ba, 1'h1);
        valley_cyc = 16'h32;
        pulses(2'h2, 20);
        chk_bit(overload_fault, 1'h0);
        trip_cyc = 16'h1e;
        pulses(2'h3, 1);
        chk_bit(len >= 32'h19 && len <= 32'h28, 1'h1);
        pulses(2'h3, 2);
        pulses(2'h0, 1);
        pulses(2'h3, 3);
        chk_bit(fault_active, 1'h0);
        pulses(2'h3, 1);
        wait_obs(3'h3, 1'h1, 32'h14, n);
        supply_start_level = 1'h0;
        supply_stop_level = 1'h1;
        wait_obs(3'h4, 1'h1, 32'h32, n);
        wait_obs(3'h4, 1'h0, 32'h3e8, n);
        chk_bit(n >= 32'hbe && n <= 32'hd7, 1'h1);
        supply_stop_level = 1'h0;
        supply_start_level = 1'h1;
        trip_cyc = 16'h64;
        pulses(2'h0, 1);
        wait_obs(3'h1, 1'h0, 32'h1770, n);
        wait_obs(3'h0, 1'h0, 32'h1b58, n);
        fault_input_trip = 1'h1;
        wait_obs(3'h3, 1'h1, 32'h32, n);
        fault_input_trip = 1'h0;
        // Latching option
        do_reset(1'h1);
        supply_start_level = 1'h1;
        wait_obs(3'h1, 1'h1, 32'h32, n);
        wait_obs(3'h1, 1'h0, 32'h1770, n);
        mode = 2'h1;
        repeat (32'h578) @(negedge clk);
        chk_bit(overload_fault, 1'h0);
        wait_obs(3'h2, 1'h1, 32'hbb8, n);
        wait_obs(3'h4, 1'h1, 32'h32, n);
        supply_stop_level = 1'h1;
        quiet(32'h1f4, q);
        chk_bit(q || !supply_hold_level, 1'h0);
        supply_clear_level = 1'h1;
        wait_obs(3'h4, 1'h0, 32'h32, n);
        supply_clear_level = 1'h0;
        supply_stop_level = 1'h0;
        pulses(2'h0, 1);
        thermal_trip_level = 1'h1;
        quiet(32'h3e8, q);
        chk_bit(q, 1'h0);
        thermal_trip_level = 1'h0;
        supply_start_level = 1'h0;
        brownout_fault = 1'h1;
        supply_stop_level = 1'h1;
        repeat (32'h14) @(negedge clk);
        supply_stop_level = 1'h0;
        supply_start_level = 1'h1;
        quiet(32'h1f4, q);
        chk_bit(q, 1'h0);
        brownout_fault = 1'h0;
        supply_start_level = 1'h0;
        repeat (32'h14) @(negedge clk);
        supply_start_level = 1'h1;
        pulses(2'h0, 1);
        end_of_test;
    end
endmodule // tb_flyback_peak_current_protection
